// ### verilog/crtc_htiming_pkg.sv
// Purpose: Shared constants for the horizontal raster timing block
// Assumes: Host I/O cycles are synchronous to i_clk
// Notes:   Register indices are CRT index values
package crtc_htiming_pkg;
    localparam logic [15:0] color_index_port    = 16'h03d4;
    localparam logic [15:0] color_data_port     = 16'h03d5;
    localparam logic [15:0] mono_index_port     = 16'h03b4;
    localparam logic [15:0] mono_data_port      = 16'h03b5;
    localparam logic [15:0] misc_out_write_port = 16'h03c2;
    localparam logic [15:0] misc_out_read_port  = 16'h03cc;
    localparam int          io_select_bit       = 0;
    localparam int          index_hidden_bit    = 5;
    localparam int          index_field_width   = 5;
    localparam int          reg_count           = 32;
    localparam logic [4:0]  idx_line_total      = 5'h00;
    localparam logic [4:0]  idx_display_end     = 5'h01;
    localparam logic [4:0]  idx_blank_start     = 5'h02;
    localparam logic [4:0]  idx_blank_end       = 5'h03;
    localparam logic [4:0]  idx_retrace_end     = 5'h05;
    localparam logic [4:0]  idx_last_extended   = 5'h1d;
    localparam logic [4:0]  idx_attr_state_low  = 5'h04;
    localparam logic [7:0]  idx_attr_state      = 8'h24;
    localparam int          skew_lsb            = 5;
    localparam int          blank_end_hi_bit    = 7;
    localparam logic [7:0]  index_reset         = 8'h00;
    localparam logic [7:0]  misc_out_reset      = 8'h00;
    localparam logic [7:0]  data_reset          = 8'h00;
    localparam logic [3:0]  dots_narrow         = 4'h8;
    localparam logic [3:0]  dots_wide           = 4'h9;
endpackage

// ### verilog/crtc_reg_mem.sv
// Purpose: Register store for the CRT data registers
// Assumes: One write port, one registered read port
// Notes:   Read data lags the address by one clock
`timescale 1ns/1ps
`default_nettype none
module crtc_reg_mem #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_ce,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [7:0]    o_rdata
);
    import crtc_htiming_pkg::*;
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = mem_q[i_raddr];
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= data_reset;
            end
            o_rdata <= data_reset;
        end else if (i_ce) begin
            if (i_we) begin
                mem_q[i_waddr] <= i_wdata;
            end
            o_rdata <= rdata_d;
        end
    end
endmodule // crtc_reg_mem
`default_nettype wire

// ### verilog/crtc_htiming.sv
// Purpose: Horizontal raster timing of the CRT controller with index/data ports
// Assumes: I/O strobes are one-cycle pulses synchronous to i_clk
// Notes:   Read data and hit valid two cycles after the read strobe
// Functional notes
// R1 - Color emulation decodes index port 3D4 and data port 3D5.
// R2 - Monochrome emulation decodes index port 3B4 and data port 3B5 instead.
// R3 - Misc output I/O select bit chooses monochrome or color ports.
// R4 - Index bits 4..0 select the data register reached.
// R5 - Indices 00-1D map to the register set; 24 is attribute state.
// R6 - Index 24 reachable only with index bit 5 written as one.
// R7 - Software programs line total as characters per line minus five; here the counter wraps after line total, so a line is line total plus one.
// R8 - Text mode counter advances once per character sent.
// R9 - Graphics mode counter advances every 8 or 9 pixels.
// R10 - Counter returns to zero after reaching line total.
// R11 - All timing events are in character clock units.
// R12 - Software programs display end as displayed characters minus one.
// R13 - Display enable active from line start for display-end length.
// R14 - Blanking begins when counter equals blank start.
// R15 - Display data suppressed while blanking.
// R16 - End-blank bits 6..5 skew the character clock by 0 to 3.
// R17 - End-blank bits 4..0 hold low bits of the blank end value.
// R18 - Blank end compares six counter bits; sixth from retrace-end bit 7.
// R19 - Blanking ends on first later match of the six-bit end value.
// R20 - Timing register writes act at the next counter comparison.
`timescale 1ns/1ps
`default_nettype none
module crtc_htiming (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [7:0]  i_io_wdata,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic        i_pixel_tick,
    input  wire logic        i_graphics_mode,
    input  wire logic        i_nine_dot,
    input  wire logic [7:0]  i_pixel_data,
    output logic      [7:0]  o_io_rdata,
    output logic             o_io_hit,
    output logic             o_char_tick,
    output logic      [7:0]  o_char_count,
    output logic             o_display_enable,
    output logic             o_hblank,
    output logic      [7:0]  o_video_data
);
    import crtc_htiming_pkg::*;

    typedef enum logic [1:0] {
        blank_off_type = 2'b00,
        blank_on_type  = 2'b01
    } blank_state_type;

    function automatic logic port_match(input logic [15:0] a, input logic mono,
                                        input logic [15:0] mp, input logic [15:0] cp);
        port_match = mono ? (a == mp) : (a == cp);
    endfunction

    // Pixel-domain inputs arrive from pins: two-stage sync
    logic [1:0] tick_sync_q;
    logic [1:0] gfx_sync_q;
    logic [1:0] nine_sync_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_sync_q <= 2'b00;
            gfx_sync_q  <= 2'b00;
            nine_sync_q <= 2'b00;
        end else if (i_ce) begin
            tick_sync_q <= {tick_sync_q[0], i_pixel_tick};
            gfx_sync_q  <= {gfx_sync_q[0], i_graphics_mode};
            nine_sync_q <= {nine_sync_q[0], i_nine_dot};
        end
    end

    // Host port state
    logic [7:0] index_q, index_d;
    logic [7:0] misc_q, misc_d;
    logic [7:0] attr_q, attr_d;
    logic [7:0] line_total_field, line_total_d;
    logic [7:0] display_end_field, display_end_d;
    logic [7:0] blank_start_field, blank_start_d;
    logic [7:0] blank_end_field, blank_end_d;
    logic [7:0] retrace_end_q, retrace_end_d;
    logic       rd_attr_q, rd_attr_d;
    logic       rd_mem_q, rd_mem_d;
    logic       rd_other_q, rd_other_d;
    logic [7:0] rd_other_val_q, rd_other_val_d;
    logic       io_hit_d;
    logic       io_hit_q;
    logic [7:0] io_rdata_d;
    logic       mono;
    logic       idx_hit, dat_hit, attr_sel, std_sel, mem_we;
    logic [7:0] mem_rdata;

    always_comb begin
        mono     = ~misc_q[io_select_bit];                                  // see R3
        idx_hit  = port_match(i_io_addr, mono, mono_index_port, color_index_port); // see R1 see R2
        dat_hit  = port_match(i_io_addr, mono, mono_data_port, color_data_port);   // see R1 see R2
        attr_sel = (index_q == idx_attr_state);                             // see R6
        std_sel  = ~index_q[index_hidden_bit]
                   && (index_q[index_field_width-1:0] <= idx_last_extended); // see R4 see R5
        mem_we   = i_io_wr && dat_hit && std_sel;
        index_d  = (i_io_wr && idx_hit) ? i_io_wdata : index_q;
        misc_d   = (i_io_wr && i_io_addr == misc_out_write_port) ? i_io_wdata : misc_q;
        attr_d   = (i_io_wr && dat_hit && attr_sel) ? i_io_wdata : attr_q;
        line_total_d  = line_total_field;
        display_end_d = display_end_field;
        blank_start_d = blank_start_field;
        blank_end_d   = blank_end_field;
        retrace_end_d = retrace_end_q;
        if (mem_we) begin                                                   // see R20
            case (index_q[index_field_width-1:0])
                idx_line_total:  line_total_d  = i_io_wdata;
                idx_display_end: display_end_d = i_io_wdata;
                idx_blank_start: blank_start_d = i_io_wdata;
                idx_blank_end:   blank_end_d   = i_io_wdata;
                idx_retrace_end: retrace_end_d = i_io_wdata;
                default:         retrace_end_d = retrace_end_q;
            endcase
        end
        rd_attr_d      = i_io_rd && dat_hit && attr_sel;
        rd_mem_d       = i_io_rd && dat_hit && std_sel;
        rd_other_d     = i_io_rd && (idx_hit || i_io_addr == misc_out_read_port);
        rd_other_val_d = idx_hit ? index_q : misc_q;
        io_hit_d       = rd_attr_d || rd_mem_d || rd_other_d;
    end

    crtc_reg_mem #(
        .DEPTH (reg_count),
        .AW    (index_field_width)
    ) u_mem (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_we    (mem_we),
        .i_waddr (index_q[index_field_width-1:0]),
        .i_wdata (i_io_wdata),
        .i_raddr (i_io_rd ? index_q[index_field_width-1:0] : index_q[index_field_width-1:0]),
        .o_rdata (mem_rdata)
    );

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            index_q           <= index_reset;
            misc_q            <= misc_out_reset;
            attr_q            <= data_reset;
            line_total_field  <= data_reset;
            display_end_field <= data_reset;
            blank_start_field <= data_reset;
            blank_end_field   <= data_reset;
            retrace_end_q     <= data_reset;
            rd_attr_q         <= 1'b0;
            rd_mem_q          <= 1'b0;
            rd_other_q        <= 1'b0;
            rd_other_val_q    <= data_reset;
            io_hit_q          <= 1'b0;
            o_io_hit          <= 1'b0;
            o_io_rdata        <= data_reset;
        end else if (i_ce) begin
            index_q           <= index_d;
            misc_q            <= misc_d;
            attr_q            <= attr_d;
            line_total_field  <= line_total_d;
            display_end_field <= display_end_d;
            blank_start_field <= blank_start_d;
            blank_end_field   <= blank_end_d;
            retrace_end_q     <= retrace_end_d;
            rd_attr_q         <= rd_attr_d;
            rd_mem_q          <= rd_mem_d;
            rd_other_q        <= rd_other_d;
            rd_other_val_q    <= rd_other_val_d;
            io_hit_q          <= io_hit_d;
            o_io_hit          <= io_hit_q;
            o_io_rdata        <= io_rdata_d;
        end
    end

    // Read mux after the memory register; hit is delayed to stay aligned
    always_comb begin
        io_rdata_d = rd_mem_q ? mem_rdata : rd_attr_q ? attr_q :
                     rd_other_q ? rd_other_val_q : data_reset;
    end

    // Character clock from synchronised pixel ticks
    logic [3:0] dot_q, dot_d;
    logic       char_raw;
    logic [3:0] dots_per_char;
    always_comb begin
        dots_per_char = nine_sync_q[1] ? dots_wide : dots_narrow;           // see R9
        char_raw      = 1'b0;
        dot_d         = dot_q;
        if (tick_sync_q[1]) begin
            if (!gfx_sync_q[1]) begin
                char_raw = 1'b1;                                            // see R8
                dot_d    = 4'h0;
            end else if (dot_q == dots_per_char - 4'h1) begin
                char_raw = 1'b1;                                            // see R9
                dot_d    = 4'h0;
            end else begin
                dot_d = dot_q + 4'h1;
            end
        end
    end

    // Skew delay line, 0 to 3 i_clk cycles
    logic [3:0] skew_q, skew_d;
    logic       char_tick;
    logic [1:0] skew_sel;
    always_comb begin
        skew_sel  = blank_end_field[skew_lsb+1:skew_lsb];                  // see R16
        skew_d    = char_raw ? {skew_q[2:0], 1'b1} : {skew_q[2:0], 1'b0};
        char_tick = (skew_sel == 2'b00) ? char_raw : skew_q[skew_sel - 2'b01];
    end

    // Horizontal counter and compares, all in character ticks
    logic [7:0]      count_q, count_d;
    logic            de_q, de_d;
    blank_state_type blank_q, blank_d;
    logic [5:0]      blank_end6;
    logic [7:0]      video_d;
    always_comb begin
        blank_end6 = {retrace_end_q[blank_end_hi_bit], blank_end_field[4:0]}; // see R17 see R18
        count_d = count_q;
        de_d    = de_q;
        blank_d = blank_q;
        if (char_tick) begin                                                // see R11
            count_d = (count_q == line_total_field) ? 8'h00 : count_q + 8'h01; // see R10
            if (count_d == 8'h00) begin
                de_d = 1'b1;                                                // see R13
            end else if (count_q == display_end_field) begin
                de_d = 1'b0;                                                // see R13
            end
            case (blank_q)
                blank_off_type: begin
                    if (count_d == blank_start_field) begin
                        blank_d = blank_on_type;                            // see R14
                    end
                end
                blank_on_type: begin
                    if (count_d[5:0] == blank_end6) begin
                        blank_d = blank_off_type;                           // see R19
                    end
                end
                default: blank_d = blank_off_type;
            endcase
        end
        video_d = (blank_q == blank_on_type || !de_q) ? 8'h00 : i_pixel_data; // see R15
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dot_q            <= 4'h0;
            skew_q           <= 4'h0;
            count_q          <= 8'h00;
            de_q             <= 1'b0;
            blank_q          <= blank_off_type;
            o_char_tick      <= 1'b0;
            o_char_count     <= 8'h00;
            o_display_enable <= 1'b0;
            o_hblank         <= 1'b0;
            o_video_data     <= 8'h00;
        end else if (i_ce) begin
            dot_q            <= dot_d;
            skew_q           <= skew_d;
            count_q          <= count_d;
            de_q             <= de_d;
            blank_q          <= blank_d;
            o_char_tick      <= char_tick;
            o_char_count     <= count_d;
            o_display_enable <= de_d;
            o_hblank         <= (blank_d == blank_on_type);
            o_video_data     <= video_d;
        end
    end

    // Checks
    sequence s_wrap_seen;
        i_ce && char_tick && (count_q == line_total_field);
    endsequence

    a_counter_wrap: assert property (@(posedge i_clk) disable iff (i_rst) // see R10
        s_wrap_seen |=> count_q == 8'h00)
        else $error("counter did not wrap at line total");

    a_counter_step: assert property (@(posedge i_clk) disable iff (i_rst) // see R8
        i_ce && char_tick && count_q != line_total_field |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not advance by one");

    a_counter_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see R11
        !char_tick |=> count_q == $past(count_q))
        else $error("counter moved without character tick");

    a_blank_start: assert property (@(posedge i_clk) disable iff (i_rst) // see R14
        i_ce && char_tick && blank_q == blank_off_type && count_d == blank_start_field
        |=> blank_q == blank_on_type ##1 o_hblank || blank_q == blank_on_type)
        else $error("blanking did not begin at start value");

    a_blank_video: assert property (@(posedge i_clk) disable iff (i_rst) // see R15
        i_ce && blank_q == blank_on_type |=> o_video_data == 8'h00)
        else $error("video passed during blanking");

    a_graphic_rate: assert property (@(posedge i_clk) disable iff (i_rst) // see R9
        gfx_sync_q[1] && char_raw |-> dot_q == dots_per_char - 4'h1)
        else $error("graphics character clock off its dot count");

    a_index_write: assert property (@(posedge i_clk) disable iff (i_rst) // see R1
        i_ce && i_io_wr && idx_hit |=> index_q == $past(i_io_wdata))
        else $error("index port write lost");

    a_mono_decode: assert property (@(posedge i_clk) disable iff (i_rst) // see R2
        !misc_q[io_select_bit] && i_io_addr == color_index_port |-> !idx_hit)
        else $error("color index decoded in monochrome emulation");

    a_hidden_gate: assert property (@(posedge i_clk) disable iff (i_rst) // see R6
        i_ce && i_io_wr && dat_hit && !index_q[index_hidden_bit]
        |=> attr_q == $past(attr_q))
        else $error("attribute state written without hidden bit");
endmodule // crtc_htiming
`default_nettype wire

// ### verification/crt_monitor_model.sv
// Purpose: Pixel source and raster monitor beside the horizontal timing block
// Assumes: Pixel pulses are one clock wide and spaced TICK_GAP clocks apart
// Notes:   Measures each line from one display-enable rise to the next
`timescale 1ns/1ps
`default_nettype none
module crt_monitor_model #(
    parameter int TICK_GAP = 2
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_display_enable,
    input  wire logic       i_hblank,
    input  wire logic [7:0] i_video_data,
    output logic            o_pixel_tick,
    output logic      [7:0] o_pixel_data,
    output int              o_line_cycles,
    output int              o_de_cycles,
    output int              o_blank_cycles,
    output int              o_lines,
    output int              o_leaks,
    output int              o_shown
);
    int   gap_q;
    int   line_c;
    int   de_c;
    int   blank_c;
    logic de_q;
    logic blank_q;
    // Constant pattern so only the blanking and display-enable gate decides what reaches the screen
    assign o_pixel_data = 8'hc3;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_q <= 0; o_pixel_tick <= 1'b0; de_q <= 1'b0; blank_q <= 1'b0;
            line_c <= 0; de_c <= 0; blank_c <= 0; o_lines <= 0; o_leaks <= 0;
            o_shown <= 0; o_line_cycles <= 0; o_de_cycles <= 0; o_blank_cycles <= 0;
        end else begin
            gap_q        <= (gap_q == TICK_GAP - 1) ? 0 : gap_q + 1;
            o_pixel_tick <= (gap_q == 0);
            de_q         <= i_display_enable;
            blank_q      <= i_hblank;
            // Settled blanking or no display: screen must stay dark
            if (((blank_q && i_hblank) || (!de_q && !i_display_enable))
                && i_video_data !== 8'h00) begin
                o_leaks <= o_leaks + 1;
            end
            if (de_q && i_display_enable && !blank_q && !i_hblank
                && i_video_data === 8'hc3) begin
                o_shown <= o_shown + 1;
            end
            if (i_display_enable && !de_q) begin
                o_line_cycles  <= line_c;
                o_de_cycles    <= de_c;
                o_blank_cycles <= blank_c;
                o_lines        <= o_lines + 1;
                line_c         <= 1;
                de_c           <= 1;
                blank_c        <= int'(i_hblank);
            end else begin
                line_c  <= line_c + 1;
                de_c    <= de_c + int'(i_display_enable);
                blank_c <= blank_c + int'(i_hblank);
            end
        end
    end
endmodule // crt_monitor_model
`default_nettype wire

// ### verification/crtc_htiming_tb.sv
// Purpose: Self-checking bench for the horizontal raster timing block
// Assumes: Host cycles are one-clock strobes launched after a rising edge
// Notes:   Line measurements come from the monitor model in clock cycles
`timescale 1ns/1ps
`default_nettype none
module crtc_htiming_tb;
    import crtc_htiming_pkg::*;
    localparam int GAP = 2;
    logic        i_clk = 1'b0, i_rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
    logic        gfx = 1'b0, nine = 1'b0, pix_tick, char_tick, de, hblank, io_hit;
    logic [15:0] io_addr = 16'h0000, idx_port, dat_port;
    logic [7:0]  io_wdata = 8'h00, pix_data, io_rdata, char_count, video, rd_v;
    logic        hit_v;
    int          err_count = 0, n_compared = 0, cycles = 0;
    int          line_cy, de_cy, blank_cy, lines, leaks, shown;
    always #5 i_clk = ~i_clk;
    crtc_htiming i_crtc_htiming (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_io_addr(io_addr), .i_io_wdata(io_wdata), .i_io_wr(io_wr), .i_io_rd(io_rd),
        .i_pixel_tick(pix_tick), .i_graphics_mode(gfx), .i_nine_dot(nine),
        .i_pixel_data(pix_data), .o_io_rdata(io_rdata), .o_io_hit(io_hit),
        .o_char_tick(char_tick), .o_char_count(char_count), .o_display_enable(de),
        .o_hblank(hblank), .o_video_data(video));
    crt_monitor_model #(.TICK_GAP(GAP)) i_crt_monitor_model (.i_clk(i_clk), .i_rst(i_rst),
        .i_display_enable(de), .i_hblank(hblank), .i_video_data(video),
        .o_pixel_tick(pix_tick), .o_pixel_data(pix_data), .o_line_cycles(line_cy),
        .o_de_cycles(de_cy), .o_blank_cycles(blank_cy), .o_lines(lines),
        .o_leaks(leaks), .o_shown(shown));
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count = err_count + 1;
            $display("Error at %0t: run did not finish", $time);
            tally_and_finish();
        end
    end
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        io_addr  <= addr;
        io_wdata <= data;
        io_wr    <= 1'b1;
        @(posedge i_clk);
        io_wr    <= 1'b0;
    endtask
    task automatic io_read(input logic [15:0] addr);
        @(posedge i_clk);
        io_addr <= addr;
        io_rd   <= 1'b1;
        @(posedge i_clk);
        io_rd   <= 1'b0;
        @(posedge i_clk);
        #1;
        rd_v  = io_rdata;
        hit_v = io_hit;
    endtask
    task automatic crt_set(input logic [7:0] index, input logic [7:0] value);
        io_write(idx_port, index);
        io_write(dat_port, value);
    endtask
    task automatic crt_expect(input logic [7:0] index, input logic [7:0] value, input logic hit);
        io_write(idx_port, index);
        io_read(dat_port);
        check_byte(rd_v, value, "data port read");
        check_bit(hit_v, hit, "data port hit");
    endtask
    task automatic measure(input int cpc, input int chars, input int shown_c, input int blank_c);
        int start;
        start = lines;
        for (int i = 0; i < 8000 && lines < start + 3; i++) @(posedge i_clk);
        check_count(line_cy, chars * cpc, "line cycles");
        check_count(de_cy, shown_c * cpc, "display cycles");
        check_count(blank_cy, blank_c * cpc, "blank cycles");
    endtask
    initial begin
        idx_port = mono_index_port;
        dat_port = mono_data_port;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        crt_set(8'h02, 8'h10);
        crt_expect(8'h02, 8'h10, 1'b1);
        io_read(color_data_port);
        check_bit(hit_v, 1'b0, "color port while mono");
        io_write(misc_out_write_port, 8'h01);
        io_read(misc_out_read_port);
        check_byte(rd_v, 8'h01, "misc output read");
        idx_port = color_index_port;
        dat_port = color_data_port;
        crt_expect(8'h02, 8'h10, 1'b1);
        io_read(mono_data_port);
        check_bit(hit_v, 1'b0, "mono port while color");
        $display("test port decode done");
        crt_set(8'h04, 8'h33);
        crt_set(8'h1d, 8'ha5);
        crt_set(idx_attr_state, 8'h5a);
        io_read(idx_port);
        check_byte(rd_v, idx_attr_state, "index read");
        crt_expect(8'h04, 8'h33, 1'b1);
        crt_expect(8'h1d, 8'ha5, 1'b1);
        crt_expect(idx_attr_state, 8'h5a, 1'b1);
        crt_expect(8'h3e, 8'h00, 1'b0);
        $display("test index map done");
        crt_set({3'h0, idx_line_total}, 8'h2f);
        crt_set({3'h0, idx_display_end}, 8'h1f);
        crt_set({3'h0, idx_blank_start}, 8'h22);
        crt_set({3'h0, idx_blank_end}, 8'h0a);
        crt_set({3'h0, idx_retrace_end}, 8'h80);
        measure(GAP, 48, 32, 8);
        @(posedge i_clk iff (char_tick === 1'b1 && char_count === 8'h2f));
        @(posedge i_clk iff char_tick === 1'b1);
        check_byte(char_count, 8'h00, "count after line total");
        gfx <= 1'b1;
        measure(GAP * 8, 48, 32, 8);
        nine <= 1'b1;
        measure(GAP * 9, 48, 32, 8);
        $display("test character clock done");
        gfx <= 1'b0;
        crt_set({3'h0, idx_retrace_end}, 8'h00);
        measure(GAP, 48, 32, 24);
        for (int s = 0; s < 4; s++) begin
            crt_set({3'h0, idx_blank_end}, {1'b0, s[1:0], 5'h0a});
            crt_expect({3'h0, idx_blank_end}, {1'b0, s[1:0], 5'h0a}, 1'b1);
            measure(GAP, 48, 32, 24);
        end
        check_count(leaks, 0, "video while blanked");
        check_bit(shown > 0, 1'b1, "video shown in display");
        $display("test blanking done");
        tally_and_finish();
    end
endmodule // crtc_htiming_tb
`default_nettype wire
